// >>> verilog/ring_pkg.sv
/*
 * Shared constants and types of the contouring command path: shared-memory map,
 * command codes, interrupt bits, timing and the segment output carrier.
 * Assumes a byte-wide shared memory of 2 KiB seen by host and controller alike.
 */
package ring_pkg;

	// ----------------------------------------------------------------
	// shared memory map
	// ----------------------------------------------------------------
	localparam int          MEM_AW     = 11;
	localparam int          MEM_DW     = 8;
	localparam logic [10:0] MEM_LAST   = 11'h7FF;
	localparam logic [10:0] CMD_ADDR   = 11'h3C2;
	localparam logic [10:0] ARG_ADDR   = 11'h3C3;
	localparam logic [10:0] IRQ_ADDR   = 11'h7FE;
	localparam logic [10:0] SIG_ADDR   = 11'h7FC;
	localparam logic [10:0] SO_BASE    = 11'h120;
	localparam logic [10:0] CU_BASE    = 11'h400;
	localparam logic [10:0] SO_PROD    = 11'h110;
	localparam logic [10:0] SO_CONS    = 11'h111;
	localparam logic [10:0] CU_PROD    = 11'h112;
	localparam logic [10:0] CU_CONS    = 11'h113;
	localparam logic [6:0]  SO_RECS    = 7'h54;
	localparam logic [6:0]  CU_RECS    = 7'h7E;
	localparam logic [2:0]  REC_LAST   = 3'h7;

	// ----------------------------------------------------------------
	// commands and arguments
	// ----------------------------------------------------------------
	localparam int         ARG_MAX      = 9;
	localparam logic [7:0] CMD_PTMOVE   = 8'h60;
	localparam logic [7:0] CMD_FERR     = 8'h67;
	localparam logic [7:0] CMD_START    = 8'h70;
	localparam logic [7:0] CMD_STOP     = 8'h71;
	localparam logic [7:0] CMD_SO_RATE  = 8'h72;
	localparam logic [7:0] CMD_CU_RATE  = 8'h73;
	localparam logic [7:0] CMD_BUF_LOW  = 8'h74;
	localparam logic [7:0] CMD_AXSET    = 8'h75;
	localparam logic [7:0] CMD_VELLOOP  = 8'h76;
	localparam logic [7:0] CMD_RESET    = 8'h77;
	localparam logic [1:0] VQ_DEPTH     = 2'h3;

	// ----------------------------------------------------------------
	// interrupt byte bits and signature
	// ----------------------------------------------------------------
	localparam int         IRQ_W        = 5;
	localparam int         IRQB_RESET   = 0;
	localparam int         IRQB_LOW     = 1;
	localparam int         IRQB_OVF     = 2;
	localparam int         IRQB_CONFL   = 3;
	localparam int         IRQB_UNDER   = 4;
	// arbitrary value, names no maker or part
	localparam logic [15:0] SIG_VALUE   = 16'hA55A;

	// ----------------------------------------------------------------
	// timing: one rate unit is 200 us at 40 MHz
	// ----------------------------------------------------------------
	localparam int RATE_UNIT_NS  = 200000;
	localparam int CLK_NS        = 25;
	localparam int RATE_UNIT_CYC = (RATE_UNIT_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic        valid;
		logic        cubic;
		logic [1:0]  axis;
		logic [31:0] pos;
		logic [31:0] vel;
	} seg_out_t;

endpackage

// >>> verilog/shared_mem.sv
/*
 * Byte-wide dual-port memory with registered read data on both ports.
 * Assumes the two ports never write one address in the same cycle; if they do,
 * port b wins.
 */
module shared_mem #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	input  wire logic          clk_i,   // clock
	input  wire logic [AW-1:0] a_addr_i, // port a address
	input  wire logic          a_we_i,  // port a write
	input  wire logic [DW-1:0] a_wd_i,  // port a write data
	output logic      [DW-1:0] a_q_o,   // port a read data
	input  wire logic [AW-1:0] b_addr_i, // port b address
	input  wire logic          b_we_i,  // port b write
	input  wire logic [DW-1:0] b_wd_i,  // port b write data
	output logic      [DW-1:0] b_q_o    // port b read data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (a_we_i) begin
			mem[a_addr_i] <= a_wd_i;
		end
		if (b_we_i) begin
			mem[b_addr_i] <= b_wd_i;
		end
		a_q_o <= mem[a_addr_i];
		b_q_o <= mem[b_addr_i];
	end

endmodule // shared_mem

// >>> verilog/contour_segment_ring_buffer.sv
/*
 * Controller side of the host command path: Avalon-MM byte slave onto the shared
 * memory, command mailbox engine, contouring ring consumer and interrupt byte.
 * Assumes the host keeps the mailbox and ring protocol of the shared memory.
 */
// How it works
// - two rings, second order low, cubic high
// - rings hold 84 and 126 records
// - record holds 32-bit position then velocity
// - next segment only after previous completes
// - interval per type set by rate command
// - addresses and index wrap at ring end
// - indices count 8-byte records from base
// - consumer index advances on every record read
// - equal indices mean ring empty
// - interrupt when unread count falls below threshold
// - start command begins contouring on axis mask
// - queue three axis-set changes, flag fourth
// - cubic axis set from velocity upper nibble
// - stop command or emergency halt ends contouring
// - conflicting motion command ignored and flagged
// - reset clears, interrupts, then writes signature
// - poll code, interpret, then write zero
// - controller clears interrupt bits only at reset
module contour_segment_ring_buffer #(
	parameter int RATE_CYC = ring_pkg::RATE_UNIT_CYC
) (
	input  wire logic              CLK_I,             // 40 MHz clock
	input  wire logic              RST_N_I,           // synchronous reset, low
	input  wire logic [10:0]       AVS_ADDRESS_I,     // byte address
	input  wire logic              AVS_READ_I,        // read request
	input  wire logic              AVS_WRITE_I,       // write request
	input  wire logic [7:0]        AVS_WRITEDATA_I,   // write data
	output logic      [7:0]        AVS_READDATA_O,    // read data
	output logic                   AVS_WAITREQUEST_O, // stall
	input  wire logic              EMERGENCY_HALT_I,  // emergency halt input, high
	output logic                   HOST_IRQ_O,        // host interrupt line
	output ring_pkg::seg_out_t     SEG_O,             // consumed record strobe
	output logic      [3:0]        CONTOUR_AXES_O,    // axes contouring
	output logic      [3:0]        CLOSED_LOOP_AXES_O, // axes in closed loop
	output logic      [63:0]       FERR_LIMIT_O       // per-axis error thresholds
);
	import ring_pkg::*;

	typedef enum logic [3:0] {
		S_CLR = 4'h0, S_RSTIRQ = 4'h1, S_SIG = 4'h2, S_IDLE = 4'h3,
		S_CMD = 4'h4, S_ARG = 4'h5, S_EXEC = 4'h6, S_ACK = 4'h7,
		S_PTR = 4'h8, S_REC = 4'h9, S_CONS = 4'hA, S_IRQ = 4'hB
	} state_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] low_axis(input logic [3:0] m);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) r = 2'(i);
		end
		return r;
	endfunction

	function automatic logic [6:0] fill(input logic [6:0] p, input logic [6:0] c, input logic [6:0] n);
		return (p >= c) ? 7'(p - c) : 7'(p + n - c);
	endfunction

	function automatic logic [63:0] ferr_unpack(input logic [63:0] old, input logic [3:0] m,
						    input logic [ARG_MAX*8-1:0] a);
		logic [63:0] r;
		int          off;
		r   = old;
		off = 1;
		for (int i = 0; i < 4; i++) begin
			if (m[i]) begin
				r[i*16 +: 16] = a[off*8 +: 16];
				off = off + 2;
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	state_t              state_r;
	logic                ph_r, pri_r, soft_rst_r, rst;
	logic [10:0]         cnt_r;
	logic [7:0]          code_r, mb_q, mb_wd;
	logic [ARG_MAX*8-1:0] arg_r;
	logic [63:0]         rec_r;
	logic [6:0]          prod_r, cons_r [2], cons_nxt, recs;
	logic [10:0]         mb_addr, base;
	logic                mb_we, waitreq_r, host_we;
	logic                run_r, fetch_r, first_r, cubic_r, under_r, timing_r;
	logic [3:0]          cont_r, closed_r, active_r, left_r, seg_mask, mask_a;
	logic [1:0]          seg_axis;
	logic [15:0]         so_rate_r, cu_rate_r, iv_r;
	logic [$clog2(RATE_CYC+1)-1:0] unit_r;
	logic [6:0]          bl_thr_r, vq_idx_r [3];
	logic [3:0]          vq_mask_r [3];
	logic [1:0]          vq_cnt_r;
	logic [IRQ_W-1:0]    pend_r, ev;
	logic                exec, cons_st, ptr_rd, new_seg, vq_pop, seg_fin, seg_due;
	logic [63:0]         ferr_r;

	assign rst      = !RST_N_I || soft_rst_r;
	assign mask_a   = arg_r[3:0];
	assign recs     = cubic_r ? CU_RECS : SO_RECS;
	assign base     = cubic_r ? CU_BASE : SO_BASE;
	assign cons_nxt = (cons_r[cubic_r] == 7'(recs - 7'h1)) ? 7'h0 : 7'(cons_r[cubic_r] + 7'h1);
	assign exec     = state_r == S_EXEC;
	assign ptr_rd   = state_r == S_PTR && ph_r;
	assign cons_st  = state_r == S_CONS;
	assign new_seg  = ptr_rd && mb_q[6:0] != cons_r[cubic_r] && left_r == 4'h0 && !first_r;
	assign vq_pop   = new_seg && !cubic_r && vq_cnt_r != 2'h0 && vq_idx_r[0] == cons_r[cubic_r];
	// cubic records carry their own axis set in the velocity's top nibble
	assign seg_mask = !first_r ? left_r : (rec_r[63:60] != 4'h0 ? rec_r[63:60] : active_r);
	assign seg_axis = low_axis(seg_mask);
	assign seg_fin  = cons_st && (seg_mask & ~(4'h1 << seg_axis)) == 4'h0;

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	always_comb begin
		ev = '0;
		ev[IRQB_CONFL] = exec && ((((code_r == CMD_PTMOVE) || (code_r == CMD_VELLOOP)) && |(mask_a & cont_r)) ||
			((code_r == CMD_START) && |(mask_a & closed_r)));
		ev[IRQB_OVF]   = exec && code_r == CMD_AXSET && vq_cnt_r == VQ_DEPTH;
		ev[IRQB_LOW]   = cons_st && bl_thr_r != 7'h0 &&
			fill(prod_r, cons_nxt, recs) < bl_thr_r && fill(prod_r, cons_r[cubic_r], recs) >= bl_thr_r;
		ev[IRQB_UNDER] = ptr_rd && mb_q[6:0] == cons_r[cubic_r] && !under_r;
	end

	// ----------------------------------------------------------------
	// controller port of shared memory
	// ----------------------------------------------------------------
	always_comb begin
		mb_addr = 11'h0;
		mb_we   = 1'b0;
		mb_wd   = 8'h0;
		case (state_r)
			S_CLR: begin
				mb_we   = 1'b1;
				mb_addr = cnt_r;
			end
			S_RSTIRQ: begin
				mb_we   = 1'b1;
				mb_addr = IRQ_ADDR;
				mb_wd   = 8'(1 << IRQB_RESET);
			end
			S_SIG: begin
				mb_we   = 1'b1;
				mb_addr = 11'(SIG_ADDR + cnt_r);
				mb_wd   = SIG_VALUE[cnt_r[0]*8 +: 8];
			end
			S_CMD: mb_addr = CMD_ADDR;
			S_ARG: mb_addr = 11'(ARG_ADDR + cnt_r);
			S_ACK: begin
				mb_we   = 1'b1;
				mb_addr = CMD_ADDR;
			end
			S_PTR: mb_addr = cubic_r ? CU_PROD : SO_PROD;
			S_REC: mb_addr = 11'(base + {1'b0, cons_r[cubic_r], 3'h0} + cnt_r[2:0]);
			S_CONS: begin
				mb_we   = 1'b1;
				mb_addr = cubic_r ? CU_CONS : SO_CONS;
				mb_wd   = {1'b0, cons_nxt};
			end
			S_IRQ: begin
				// read-modify-write so bits the host has not yet cleared stay set
				mb_we   = ph_r;
				mb_addr = IRQ_ADDR;
				mb_wd   = mb_q | 8'(pend_r);
			end
			default: mb_addr = 11'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			state_r <= S_CLR;
			ph_r    <= 1'b0;
			cnt_r   <= 11'h0;
			pri_r   <= 1'b0;
		end else begin
			ph_r <= !ph_r;
			case (state_r)
				S_CLR: begin
					ph_r  <= 1'b0;
					cnt_r <= 11'(cnt_r + 11'h1);
					if (cnt_r == MEM_LAST) state_r <= S_RSTIRQ;
				end
				S_RSTIRQ: begin
					ph_r    <= 1'b0;
					cnt_r   <= 11'h0;
					state_r <= S_SIG;
				end
				S_SIG: begin
					ph_r  <= 1'b0;
					cnt_r <= 11'(cnt_r + 11'h1);
					if (cnt_r[0]) state_r <= S_IDLE;
				end
				S_IDLE: begin
					ph_r  <= 1'b0;
					cnt_r <= 11'h0;
					pri_r <= !pri_r;
					// alternate so an empty ring cannot lock out the mailbox
					if (pend_r != '0) state_r <= S_IRQ;
					else if (run_r && fetch_r && !pri_r) state_r <= S_PTR;
					else state_r <= S_CMD;
				end
				S_CMD: if (ph_r) state_r <= (mb_q != 8'h0) ? S_ARG : S_IDLE;
				S_ARG: if (ph_r) begin
					cnt_r <= 11'(cnt_r + 11'h1);
					if (cnt_r == 11'(ARG_MAX - 1)) state_r <= S_EXEC;
				end
				S_EXEC: state_r <= S_ACK;
				S_ACK: state_r <= S_IDLE;
				S_PTR: if (ph_r) state_r <= (mb_q[6:0] != cons_r[cubic_r]) ? S_REC : S_IDLE;
				S_REC: if (ph_r) begin
					cnt_r <= 11'(cnt_r + 11'h1);
					if (cnt_r[2:0] == REC_LAST) state_r <= S_CONS;
				end
				S_CONS: state_r <= S_IDLE;
				S_IRQ: if (ph_r) state_r <= S_IDLE;
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// captured bytes
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			code_r <= 8'h0;
			arg_r  <= '0;
			rec_r  <= 64'h0;
			prod_r <= 7'h0;
		end else begin
			if (state_r == S_CMD && ph_r) code_r <= mb_q;
			if (state_r == S_ARG && ph_r) arg_r[cnt_r[3:0]*8 +: 8] <= mb_q;
			if (state_r == S_REC && ph_r) rec_r[cnt_r[2:0]*8 +: 8] <= mb_q;
			if (ptr_rd) prod_r <= mb_q[6:0];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= exec && code_r == CMD_RESET && !soft_rst_r;
		end
	end

	// ----------------------------------------------------------------
	// command settings
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			so_rate_r <= 16'h1;
			cu_rate_r <= 16'h1;
			bl_thr_r  <= 7'h0;
			ferr_r    <= 64'h0;
		end else if (exec) begin
			case (code_r)
				CMD_SO_RATE: so_rate_r <= arg_r[15:0];
				CMD_CU_RATE: cu_rate_r <= arg_r[15:0];
				CMD_BUF_LOW: bl_thr_r  <= arg_r[6:0];
				CMD_FERR:    ferr_r    <= ferr_unpack(ferr_r, mask_a, arg_r);
				default:     bl_thr_r  <= bl_thr_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// axis-set change queue
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			vq_cnt_r <= 2'h0;
			for (int i = 0; i < 3; i++) begin
				vq_idx_r[i]  <= 7'h0;
				vq_mask_r[i] <= 4'h0;
			end
		end else if (exec && code_r == CMD_AXSET && vq_cnt_r != VQ_DEPTH) begin
			vq_idx_r[vq_cnt_r]  <= arg_r[6:0];
			vq_mask_r[vq_cnt_r] <= arg_r[11:8];
			vq_cnt_r            <= 2'(vq_cnt_r + 2'h1);
		end else if (vq_pop) begin
			for (int i = 0; i < 2; i++) begin
				vq_idx_r[i]  <= vq_idx_r[i+1];
				vq_mask_r[i] <= vq_mask_r[i+1];
			end
			vq_cnt_r <= 2'(vq_cnt_r - 2'h1);
		end
	end

	// ----------------------------------------------------------------
	// motion state
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			run_r    <= 1'b0;
			fetch_r  <= 1'b0;
			first_r  <= 1'b0;
			cubic_r  <= 1'b0;
			under_r  <= 1'b0;
			cont_r   <= 4'h0;
			closed_r <= 4'h0;
			active_r <= 4'h0;
			left_r   <= 4'h0;
			cons_r   <= '{7'h0, 7'h0};
		end else if (EMERGENCY_HALT_I) begin
			run_r   <= 1'b0;
			fetch_r <= 1'b0;
			cont_r  <= 4'h0;
			left_r  <= 4'h0;
			first_r <= 1'b0;
		end else begin
			if (exec && !ev[IRQB_CONFL]) begin
				case (code_r)
					CMD_START: if (mask_a != 4'h0) begin
						run_r    <= 1'b1;
						fetch_r  <= 1'b1;
						cont_r   <= mask_a;
						active_r <= mask_a;
						cubic_r  <= arg_r[8];
						left_r   <= 4'h0;
						first_r  <= 1'b0;
					end
					CMD_STOP: begin
						cont_r   <= cont_r & ~mask_a;
						closed_r <= closed_r & ~mask_a;
						active_r <= active_r & ~mask_a;
						left_r   <= left_r & ~mask_a;
						if ((cont_r & ~mask_a) == 4'h0) run_r <= 1'b0;
					end
					CMD_PTMOVE, CMD_VELLOOP: closed_r <= closed_r | mask_a;
					default: run_r <= run_r;
				endcase
			end
			if (ptr_rd) under_r <= mb_q[6:0] == cons_r[cubic_r];
			if (new_seg) begin
				if (cubic_r) first_r <= 1'b1;
				else begin
					left_r   <= vq_pop ? vq_mask_r[0] : active_r;
					active_r <= vq_pop ? vq_mask_r[0] : active_r;
				end
			end
			if (cons_st) begin
				cons_r[cubic_r] <= cons_nxt;
				first_r         <= 1'b0;
				left_r          <= seg_mask & ~(4'h1 << seg_axis);
				if (first_r) active_r <= seg_mask;
				if (seg_fin) fetch_r <= 1'b0;
			end
			if (seg_due && run_r) fetch_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// segment interval timer
	// ----------------------------------------------------------------
	assign seg_due = timing_r && iv_r <= 16'h1 && unit_r == ($bits(unit_r))'(RATE_CYC - 1);

	always_ff @(posedge CLK_I) begin
		if (rst || !run_r) begin
			timing_r <= 1'b0;
			iv_r     <= 16'h0;
			unit_r   <= '0;
		end else if (seg_fin) begin
			timing_r <= 1'b1;
			iv_r     <= cubic_r ? cu_rate_r : so_rate_r;
			unit_r   <= '0;
		end else if (timing_r) begin
			if (unit_r == ($bits(unit_r))'(RATE_CYC - 1)) begin
				unit_r <= '0;
				iv_r   <= 16'(iv_r - 16'h1);
				if (iv_r <= 16'h1) timing_r <= 1'b0;
			end else begin
				unit_r <= ($bits(unit_r))'(unit_r + 1'b1);
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			pend_r <= '0;
		end else begin
			pend_r <= ((state_r == S_IRQ && ph_r) ? '0 : pend_r) | ev;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			HOST_IRQ_O <= 1'b0;
		end else if (state_r == S_RSTIRQ || (state_r == S_IRQ && ph_r)) begin
			HOST_IRQ_O <= 1'b1;
		end else if ((AVS_READ_I || AVS_WRITE_I) && !waitreq_r && AVS_ADDRESS_I == IRQ_ADDR) begin
			HOST_IRQ_O <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs and host port
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			SEG_O              <= '0;
			CONTOUR_AXES_O     <= 4'h0;
			CLOSED_LOOP_AXES_O <= 4'h0;
			FERR_LIMIT_O       <= 64'h0;
		end else begin
			SEG_O.valid        <= cons_st;
			SEG_O.cubic        <= cubic_r;
			SEG_O.axis         <= seg_axis;
			SEG_O.pos          <= rec_r[31:0];
			SEG_O.vel          <= rec_r[63:32];
			CONTOUR_AXES_O     <= cont_r;
			CLOSED_LOOP_AXES_O <= closed_r;
			FERR_LIMIT_O       <= ferr_r;
		end
	end

	// every access takes two cycles: stall, then one cycle with waitrequest low
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			waitreq_r <= 1'b1;
		end else begin
			waitreq_r <= !((AVS_READ_I || AVS_WRITE_I) && waitreq_r);
		end
	end

	assign host_we           = AVS_WRITE_I && !waitreq_r;
	assign AVS_WAITREQUEST_O = waitreq_r;

	shared_mem #(.AW(MEM_AW), .DW(MEM_DW)) u_mem (
		.clk_i    (CLK_I),
		.a_addr_i (AVS_ADDRESS_I),
		.a_we_i   (host_we),
		.a_wd_i   (AVS_WRITEDATA_I),
		.a_q_o    (AVS_READDATA_O),
		.b_addr_i (mb_addr),
		.b_we_i   (mb_we),
		.b_wd_i   (mb_wd),
		.b_q_o    (mb_q)
	);

endmodule // contour_segment_ring_buffer

// >>> verif/ring_checker.sv
/* Port assertions of the contouring command path.
   Assumes a bind onto the top module and a synchronous low reset. */
module ring_checker (
	input wire logic               CLK_I,              // clock
	input wire logic               RST_N_I,            // reset, low
	input wire logic [10:0]        AVS_ADDRESS_I,      // address
	input wire logic               AVS_READ_I,         // read
	input wire logic               AVS_WRITE_I,        // write
	input wire logic               AVS_WAITREQUEST_O,  // stall
	input wire logic               EMERGENCY_HALT_I,   // halt
	input wire logic               HOST_IRQ_O,         // interrupt
	input wire ring_pkg::seg_out_t SEG_O,              // record strobe
	input wire logic [3:0]         CONTOUR_AXES_O,     // contour axes
	input wire logic [3:0]         CLOSED_LOOP_AXES_O, // loop axes
	input wire logic [63:0]        FERR_LIMIT_O        // thresholds
);
	timeunit 1ns;
	timeprecision 100ps;
	import ring_pkg::*;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic irq_ack;
	assign irq_ack = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == IRQ_ADDR;
	// records take well over eight cycles each, so strobes never bunch
	sequence s_quiet;
		!SEG_O.valid [*8];
	endsequence
	AST_WAIT_ANS: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("access not answered in one cycle");
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("answer longer than one cycle");
	AST_RST_BUS: assert property (disable iff (1'b0) !RST_N_I |=> AVS_WAITREQUEST_O && !HOST_IRQ_O && !SEG_O.valid)
		else $error("bus outputs not idle in reset");
	AST_RST_STATE: assert property (disable iff (1'b0)
		!RST_N_I |=> CONTOUR_AXES_O == 4'h0 && CLOSED_LOOP_AXES_O == 4'h0 && FERR_LIMIT_O == 64'h0)
		else $error("motion state not cleared in reset");
	AST_SEG_GAP: assert property (SEG_O.valid |=> s_quiet)
		else $error("record strobes too close");
	AST_HALT: assert property (EMERGENCY_HALT_I [*2] |=> CONTOUR_AXES_O == 4'h0)
		else $error("contouring survives halt");
	AST_IRQ_HOLD: assert property (HOST_IRQ_O && !irq_ack |=> HOST_IRQ_O)
		else $error("interrupt dropped without host access");
	AST_EXCL: assert property ((CONTOUR_AXES_O & CLOSED_LOOP_AXES_O) == 4'h0)
		else $error("axis both contouring and in closed loop");
endmodule // ring_checker

// >>> verif/host_model.sv
/* Host model: Avalon-MM master writing the shared memory mailbox and ring.
   Assumes the tb calls its tasks one at a time. */
module host_model (
	input  wire logic        clk_i,   // clock
	input  wire logic        wait_i,  // waitrequest
	input  wire logic [7:0]  rdata_i, // read data
	output logic      [10:0] addr_o,  // address
	output logic             read_o,  // read
	output logic             write_o, // write
	output logic      [7:0]  wdata_o  // write data
);
	timeunit 1ns;
	timeprecision 100ps;
	import ring_pkg::*;
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	initial begin
		addr_o = 11'h000; read_o = 1'b0; write_o = 1'b0; wdata_o = 8'h00;
	end
	task automatic xfer(input logic [10:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		addr_o <= a; read_o <= !w; write_o <= w; wdata_o <= d;
		do @(posedge clk_i); while (wait_i !== 1'b0);
		q = rdata_i;
		// released lines show inverted values so stale data cannot pass
		read_o <= 1'b0; write_o <= 1'b0; addr_o <= ~a; wdata_o <= ~d;
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [10:0] a, output logic [7:0] q);
		xfer(a, 1'b0, 8'h00, q);
	endtask
	task automatic cmd_free;
		logic [7:0] q;
		do rd(CMD_ADDR, q); while (q !== 8'h00);
	endtask
	task automatic rtc(input logic [7:0] code, input logic [ARG_MAX*8-1:0] args, input int n);
		cmd_free();
		for (int i = 0; i < n; i++) wr(ARG_ADDR + 11'(i), args[8*i +: 8]);
		wr(CMD_ADDR, code);
		cmd_free();
	endtask
	task automatic rec(input logic [6:0] idx, input logic [31:0] p, input logic [31:0] v);
		for (int i = 0; i < 8; i++) wr(SO_BASE + 11'({idx, 3'h0}) + 11'(i), i < 4 ? p[8*i +: 8] : v[8*(i-4) +: 8]);
	endtask
endmodule // host_model

// >>> verif/tb.sv
/* Self-checking bench of the contouring command path.
   Assumes the design package is compiled first; rate unit shortened to 4. */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ring_pkg::*;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	logic        CLK_I = 1'b0, RST_N_I = 1'b0, EMERGENCY_HALT_I = 1'b0;
	logic [10:0] addr;
	logic        rd_s, wr_s, wreq, irq;
	logic [7:0]  wd, rdat, b;
	seg_out_t    seg;
	logic [3:0]  cax, clx;
	logic [63:0] ferr;
	logic [63:0] exp_q[$];
	logic [15:0] t[4];
	logic [31:0] p, v;
	int          n_mismatch = 0, checks_done = 0;
	always #12.5 CLK_I = ~CLK_I;
	host_model h_u (.clk_i(CLK_I), .wait_i(wreq), .rdata_i(rdat), .addr_o(addr), .read_o(rd_s), .write_o(wr_s),
		.wdata_o(wd));
	contour_segment_ring_buffer #(.RATE_CYC(4)) dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wreq), .EMERGENCY_HALT_I(EMERGENCY_HALT_I), .HOST_IRQ_O(irq), .SEG_O(seg),
		.CONTOUR_AXES_O(cax), .CLOSED_LOOP_AXES_O(clx), .FERR_LIMIT_O(ferr));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [63:0] ferr_exp(input logic [15:0] a, b2, c, d);
		return {d, c, b2, a};
	endfunction
	// mid-cycle sampling keeps the one-cycle strobe clear of edge races
	always @(negedge CLK_I) if (seg.valid === 1'b1) begin
		chk({seg.pos, seg.vel}, exp_q.size() > 0 ? exp_q.pop_front() : ~64'h0);
		chk(64'({seg.cubic, seg.axis}), 64'h0);
	end
	initial begin
		#1500000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		void'($urandom(96628));
		repeat (4) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		while (irq !== 1'b1) @(posedge CLK_I);
		h_u.rd(IRQ_ADDR, b); chk(64'(b), 64'h01);
		@(negedge CLK_I); chk(64'(irq), 64'h0);
		h_u.rd(SIG_ADDR, b); chk(64'(b), 64'(SIG_VALUE[7:0]));
		h_u.rd(SIG_ADDR + 11'h001, b); chk(64'(b), 64'(SIG_VALUE[15:8]));
		h_u.rd(SO_CONS, b); chk(64'(b), 64'h0);
		h_u.wr(IRQ_ADDR, 8'h00);
		for (int i = 0; i < 4; i++) t[i] = 16'($urandom());
		h_u.rtc(CMD_FERR, {t[3], t[2], t[1], t[0], 8'h0F}, 9); chk(ferr, ferr_exp(t[0], t[1], t[2], t[3]));
		h_u.rtc(CMD_PTMOVE, 72'h02, 1); chk(64'(clx), 64'h2);
		h_u.rtc(CMD_START, 72'h0002, 2); chk(64'(cax), 64'h0);
		h_u.rtc(CMD_STOP, 72'h02, 1); chk(64'(clx), 64'h0);
		repeat (4) h_u.rtc(CMD_AXSET, 72'h0150, 2);
		h_u.rd(IRQ_ADDR, b); chk(64'(b), 64'h0C);
		h_u.wr(IRQ_ADDR, 8'h00);
		h_u.rtc(CMD_SO_RATE, 72'h0001, 2);
		h_u.rtc(CMD_BUF_LOW, 72'h05, 1);
		for (int i = 0; i < 86; i++) begin
			if (i == 83) begin
				h_u.wr(SO_PROD, 8'h53);
				h_u.rtc(CMD_START, 72'h0001, 2); chk(64'(cax), 64'h1);
				do h_u.rd(SO_CONS, b); while (b !== 8'h53);
			end
			p = $urandom();
			v = $urandom();
			exp_q.push_back({p, v});
			h_u.rec(7'(i % 84), p, v);
		end
		h_u.wr(SO_PROD, 8'h02);
		do h_u.rd(SO_CONS, b); while (b !== 8'h02);
		chk(64'(exp_q.size()), 64'h0);
		repeat (200) @(posedge CLK_I);
		h_u.rd(IRQ_ADDR, b); chk(64'(b), 64'h12);
		EMERGENCY_HALT_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		@(negedge CLK_I); chk(64'(cax), 64'h0);
		h_u.rtc(CMD_RESET, 72'h0, 0);
		while (irq !== 1'b1) @(posedge CLK_I);
		h_u.rd(IRQ_ADDR, b); chk(64'(b), 64'h01);
		chk(ferr, 64'h0);
		end_of_test();
	end
endmodule // tb
bind contour_segment_ring_buffer ring_checker chk_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.EMERGENCY_HALT_I(EMERGENCY_HALT_I), .HOST_IRQ_O(HOST_IRQ_O), .SEG_O(SEG_O), .CONTOUR_AXES_O(CONTOUR_AXES_O),
	.CLOSED_LOOP_AXES_O(CLOSED_LOOP_AXES_O), .FERR_LIMIT_O(FERR_LIMIT_O));
